/* File: telemetry_readback.sv */
// read-only telemetry register bank of a dual-channel controller behind a command decoder
// assumes same-clock measurement words and decoded transactions from the bus front end
`timescale 1ns/1ps
module telemetry_readback #(
   parameter int unsigned SLOW_REFRESH_CYCLES = telemetry_pkg::SLOW_CYCLES // 1200 us
) (
   input  wire logic        clk,                            // 20 MHz system clock
   input  wire logic        rst_n,                          // sync reset, active low
   input  wire logic        cmdValid,                       // one-cycle transaction strobe
   input  wire logic [7:0]  cmdCode,                        // command code
   input  wire logic        cmdWrite,                       // transaction is a write
   input  wire logic [15:0] cmdWriteData,                   // write payload, discarded
   input  wire logic [7:0]  page,                           // current page setting
   input  wire logic [7:0]  phase,                          // current phase setting
   input  wire logic        clearFaults,                    // clear fault flags pulse
   input  wire logic [1:0][4:0]  temperatureExponent,       // hottest stage, per channel
   input  wire logic [1:0][10:0] temperatureMantissa,       // hottest stage, per channel
   input  wire logic [1:0][4:0]  outPowerExponent,          // per channel
   input  wire logic [1:0][10:0] outPowerMantissa,          // per channel
   input  wire logic [4:0]       inPowerExponent,           // shared input power
   input  wire logic [10:0]      inPowerMantissa,           // shared input power
   input  wire logic [1:0][4:0]  outVoltageExponent,        // per channel
   input  wire logic [1:0][10:0] outVoltageMantissa,        // per channel
   input  wire logic [7:0][4:0]  outCurrentExponent,        // A ph1..6, A sum, B
   input  wire logic [7:0][10:0] outCurrentMantissa,        // A ph1..6, A sum, B
   input  wire logic [10:0] inSenseRaw,                     // total input current, gain applied
   input  wire logic [7:0]  inputCurrentFullScale,          // nominal 50
   input  wire logic [4:0]  inputCurrentOffset,             // signed amps
   output logic             rdValid,                        // read word answer strobe
   output logic [15:0]      rdData,                         // read word, from register
   output logic             cmlFault,                       // communication fault flag
   output logic             statusSummary,                  // summary status flag
   output logic             hostAlertOutput                 // alert toward host
);
   import telemetry_pkg::*;

   // refresh timers and state
   refresh_state_t      state_ff, nxt_state;
   logic [TIMER_W-1:0]  slowCnt_ff, nxt_slowCnt;
   logic [TIMER_W-1:0]  fastCnt_ff, nxt_fastCnt;
   logic                slowPend_ff, nxt_slowPend;
   logic                fastPend_ff, nxt_fastPend;
   logic [ADDR_W-1:0]   wrIdx_ff, nxt_wrIdx;
   logic                slowTick, fastTick;
   logic                wrEn;

   // flags and answer
   logic                cml_ff, nxt_cml;
   logic                summary_ff, nxt_summary;
   logic                rdValid_ff, nxt_rdValid;
   logic [ADDR_W-1:0]   rdAddr;
   logic                rdHit;
   logic                ownCmd;
   logic                chanB;
   logic                phaseOne;

   logic [WORD_W-1:0]   liveWord [DEPTH];
   logic [WORD_W-1:0]   inCurrentWord;

   // terminal counts of the two refresh timers
   localparam int unsigned SLOW_LAST = SLOW_REFRESH_CYCLES - 1;
   localparam int unsigned FAST_LAST = FAST_CYCLES - 1;

   function automatic logic [WORD_W-1:0] linearWord(input logic [4:0] e,
                                                    input logic [10:0] m);
      logic [WORD_W-1:0] w;
      w                  = WORD_RESET;
      w[EXP_MSB:EXP_LSB] = e;
      w[MAN_MSB:0]       = m;
      linearWord         = w;
   endfunction

   // live word per store entry; the refresh walk copies one entry per cycle
   assign liveWord[ENT_PIN] = linearWord(inPowerExponent, inPowerMantissa);
   assign liveWord[ENT_IIN] = inCurrentWord;

   genvar gi;
   generate
      // per-channel entries sit in A/B pairs, index 0 is channel A
      for (gi = 0; gi < 2; gi++) begin : g_channel
         assign liveWord[int'(ENT_TEMP_A) + gi] =
            linearWord(temperatureExponent[gi], temperatureMantissa[gi]);
         assign liveWord[int'(ENT_POUT_A) + gi] =
            linearWord(outPowerExponent[gi], outPowerMantissa[gi]);
         assign liveWord[int'(ENT_VOUT_A) + gi] =
            linearWord(outVoltageExponent[gi], outVoltageMantissa[gi]);
      end
      // six channel A phases, the channel A sum, then channel B
      for (gi = 0; gi < 8; gi++) begin : g_current
         assign liveWord[int'(ENT_IOUT_BASE) + gi] =
            linearWord(outCurrentExponent[gi], outCurrentMantissa[gi]);
      end
   endgenerate

   // input current: total sense scaled by full-scale ratio to 50, plus offset
   logic signed [21:0] iinProduct;
   logic signed [21:0] iinScaled;
   logic signed [21:0] iinSum;
   logic        [10:0] iinMant;

   // operands widened first so the product never wraps
   always_comb begin
      iinProduct = $signed(22'(inSenseRaw)) * $signed(22'(inputCurrentFullScale));
      iinScaled  = iinProduct / $signed(22'(IIN_NOMINAL_SCALE));
      iinSum     = iinScaled + (22'($signed(inputCurrentOffset)) <<< OFS_SHIFT);
      // saturate so an overload never reads back as a small current
      if (iinSum > 22'sd1023) begin
         iinMant = 11'h3FF;
      end else if (iinSum < -22'sd1024) begin
         iinMant = 11'h400;
      end else begin
         iinMant = iinSum[10:0];
      end
      inCurrentWord = linearWord(IIN_EXPONENT, iinMant);
   end

   // refresh timers and store walk
   always_comb begin
      slowTick     = (slowCnt_ff == TIMER_W'(SLOW_LAST));
      fastTick     = (fastCnt_ff == TIMER_W'(FAST_LAST));
      nxt_slowCnt  = slowTick ? '0 : slowCnt_ff + TIMER_W'(1);
      nxt_fastCnt  = fastTick ? '0 : fastCnt_ff + TIMER_W'(1);
      nxt_slowPend = slowPend_ff;
      nxt_fastPend = fastPend_ff;
      nxt_state    = state_ff;
      nxt_wrIdx    = wrIdx_ff;
      wrEn         = 1'b0;
      case (state_ff)
         REFRESH_IDLE: begin
            // fast walk first: its entries age twelve times quicker
            if (fastPend_ff) begin
               nxt_fastPend = 1'b0;
               nxt_state    = REFRESH_FAST;
               nxt_wrIdx    = ENT_IOUT_BASE;
            end else if (slowPend_ff) begin
               nxt_slowPend = 1'b0;
               nxt_state    = REFRESH_SLOW;
               nxt_wrIdx    = ENT_TEMP_A;
            end
         end
         REFRESH_SLOW: begin
            wrEn      = 1'b1;
            nxt_wrIdx = wrIdx_ff + ADDR_W'(1);
            if (wrIdx_ff == ENT_SLOW_LAST) begin
               nxt_state = REFRESH_IDLE;
            end
         end
         REFRESH_FAST: begin
            wrEn      = 1'b1;
            nxt_wrIdx = wrIdx_ff + ADDR_W'(1);
            if (wrIdx_ff == ENT_FAST_LAST) begin
               nxt_state = REFRESH_IDLE;
            end
         end
         default: begin
            nxt_state = REFRESH_IDLE;
         end
      endcase
      // a tick in the same cycle as a start wins
      if (slowTick) begin
         nxt_slowPend = 1'b1;
      end
      if (fastTick) begin
         nxt_fastPend = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // both walks pending so the store fills right after reset
         state_ff    <= REFRESH_IDLE;
         slowCnt_ff  <= '0;
         fastCnt_ff  <= '0;
         slowPend_ff <= 1'b1;
         fastPend_ff <= 1'b1;
         wrIdx_ff    <= '0;
      end else begin
         state_ff    <= nxt_state;
         slowCnt_ff  <= nxt_slowCnt;
         fastCnt_ff  <= nxt_fastCnt;
         slowPend_ff <= nxt_slowPend;
         fastPend_ff <= nxt_fastPend;
         wrIdx_ff    <= nxt_wrIdx;
      end
   end

   // page decode: FFh asks for both channels, one word can only answer channel A
   always_comb begin
      case (page)
         PAGE_CH_B: begin
            chanB = 1'b1;
         end
         PAGE_CH_A, PAGE_BOTH: begin
            chanB = 1'b0;
         end
         default: begin
            chanB = 1'b0;
         end
      endcase
      // phases past the populated ones fall back to the channel A sum
      phaseOne = (phase < 8'(PHASES_A));
   end

   // command decode: store entry for the selected page and phase
   always_comb begin
      rdAddr = ENT_TEMP_A;
      ownCmd = 1'b1;
      case (cmdCode)
         CMD_TEMPERATURE: begin
            rdAddr = chanB ? ENT_TEMP_B : ENT_TEMP_A;
         end
         CMD_OUT_POWER: begin
            rdAddr = chanB ? ENT_POUT_B : ENT_POUT_A;
         end
         CMD_IN_POWER: begin
            rdAddr = ENT_PIN;
         end
         CMD_OUT_VOLTAGE: begin
            rdAddr = chanB ? ENT_VOUT_B : ENT_VOUT_A;
         end
         CMD_IN_CURRENT: begin
            rdAddr = ENT_IIN;
         end
         CMD_OUT_CURRENT: begin
            if (chanB) begin
               rdAddr = ENT_IOUT_B;
            end else if (phase == PHASE_SUM || phase == PHASE_ALL) begin
               rdAddr = ENT_IOUT_SUMA;
            end else if (phaseOne) begin
               rdAddr = ENT_IOUT_BASE + phase[ADDR_W-1:0];
            end else begin
               rdAddr = ENT_IOUT_SUMA;
            end
         end
         default: begin
            ownCmd = 1'b0;
         end
      endcase
      // foreign codes stay silent and raise no flag
      rdHit = cmdValid && ownCmd && !cmdWrite;
   end

   // fault flags: a write of an own command code sets them, clear wins only without a new write
   always_comb begin
      nxt_cml     = cml_ff;
      nxt_summary = summary_ff;
      if (clearFaults) begin
         nxt_cml     = 1'b0;
         nxt_summary = 1'b0;
      end
      if (cmdValid && ownCmd && cmdWrite) begin
         nxt_cml     = 1'b1;
         nxt_summary = 1'b1;
      end
      // answer one cycle after the taking edge
      nxt_rdValid = rdHit;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cml_ff     <= 1'b0;
         summary_ff <= 1'b0;
         rdValid_ff <= 1'b0;
      end else begin
         cml_ff     <= nxt_cml;
         summary_ff <= nxt_summary;
         rdValid_ff <= nxt_rdValid;
      end
   end

   // write payload never reaches the store
   telemetry_store u_store (
      .clk    (clk),
      .rst_n  (rst_n),
      .wrEn   (wrEn),
      .wrAddr (wrIdx_ff),
      .wrData (liveWord[wrIdx_ff]),
      .rdAddr (rdAddr),
      .rdData (rdData)
   );

   assign rdValid         = rdValid_ff;
   assign cmlFault        = cml_ff;
   assign statusSummary   = summary_ff;
   // alert is the fault flag itself; clearing faults releases it
   assign hostAlertOutput = cml_ff;

endmodule // telemetry_readback

/* File: telemetry_pkg.sv */
// constants for the telemetry readback bank: command codes, store map, refresh timing
// assumes a 20 MHz clock and a command decoder that hands over whole transactions
package telemetry_pkg;

   localparam int unsigned CLK_MHZ         = 20;
   localparam int unsigned SLOW_REFRESH_US = 1200;
   localparam int unsigned FAST_REFRESH_US = 100;
   localparam int unsigned SLOW_CYCLES     = SLOW_REFRESH_US * CLK_MHZ;
   localparam int unsigned FAST_CYCLES     = FAST_REFRESH_US * CLK_MHZ;
   localparam int unsigned TIMER_W         = 16;

   localparam logic [7:0] CMD_IN_CURRENT  = 8'h89;
   localparam logic [7:0] CMD_OUT_CURRENT = 8'h8C;
   localparam logic [7:0] CMD_TEMPERATURE = 8'h8D;
   localparam logic [7:0] CMD_OUT_POWER   = 8'h96;
   localparam logic [7:0] CMD_IN_POWER    = 8'h97;
   localparam logic [7:0] CMD_OUT_VOLTAGE = 8'hD4;

   localparam logic [7:0] PAGE_CH_A  = 8'h00;
   localparam logic [7:0] PAGE_CH_B  = 8'h01;
   localparam logic [7:0] PAGE_BOTH  = 8'hFF;
   localparam logic [7:0] PHASE_SUM  = 8'h80;
   localparam logic [7:0] PHASE_ALL  = 8'hFF;
   localparam int unsigned PHASES_A  = 6;

   // linear word layout
   localparam int unsigned EXP_MSB = 15;
   localparam int unsigned EXP_LSB = 11;
   localparam int unsigned MAN_MSB = 10;
   localparam int unsigned WORD_W  = 16;

   // store map
   localparam int unsigned ADDR_W        = 4;
   localparam int unsigned DEPTH         = 16;
   localparam logic [3:0]  ENT_TEMP_A    = 4'h0;
   localparam logic [3:0]  ENT_TEMP_B    = 4'h1;
   localparam logic [3:0]  ENT_POUT_A    = 4'h2;
   localparam logic [3:0]  ENT_POUT_B    = 4'h3;
   localparam logic [3:0]  ENT_PIN       = 4'h4;
   localparam logic [3:0]  ENT_VOUT_A    = 4'h5;
   localparam logic [3:0]  ENT_VOUT_B    = 4'h6;
   localparam logic [3:0]  ENT_IOUT_BASE = 4'h7;
   localparam logic [3:0]  ENT_IOUT_SUMA = 4'hD;
   localparam logic [3:0]  ENT_IOUT_B    = 4'hE;
   localparam logic [3:0]  ENT_IIN       = 4'hF;
   localparam logic [3:0]  ENT_SLOW_LAST = 4'h6;
   localparam logic [3:0]  ENT_FAST_LAST = 4'hF;

   // input current scaling
   localparam int unsigned IIN_NOMINAL_SCALE = 50;
   localparam logic [4:0]  IIN_EXPONENT      = 5'h1E;
   localparam int unsigned OFS_SHIFT         = 2;

   localparam logic [15:0] WORD_RESET = 16'h0000;

   typedef enum logic [1:0] {REFRESH_IDLE, REFRESH_SLOW, REFRESH_FAST} refresh_state_t;

endpackage

/* File: telemetry_store.sv */
// sixteen-word store for telemetry snapshots, one write port and one read port
// assumes writes always carry a complete word; read data come out of a register
`timescale 1ns/1ps
module telemetry_store (
   input  wire logic                               clk,      // system clock
   input  wire logic                               rst_n,    // sync reset, active low
   input  wire logic                               wrEn,     // write strobe
   input  wire logic [telemetry_pkg::ADDR_W-1:0]   wrAddr,   // write entry
   input  wire logic [telemetry_pkg::WORD_W-1:0]   wrData,   // whole word
   input  wire logic [telemetry_pkg::ADDR_W-1:0]   rdAddr,   // read entry
   output logic      [telemetry_pkg::WORD_W-1:0]   rdData    // registered read word
);
   import telemetry_pkg::*;

   logic [WORD_W-1:0] mem [DEPTH];
   logic [WORD_W-1:0] rdData_ff;
   logic [WORD_W-1:0] nxt_rdData;

   always_comb begin
      nxt_rdData = mem[rdAddr];
   end

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData_ff <= WORD_RESET;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign rdData = rdData_ff;

endmodule // telemetry_store

/* File: telemetry_readback_sva.sv */
// checker for the telemetry readback bank: answer timing and fault flags
// bound to the top module, sees its ports only
`timescale 1ns/1ps
module telemetry_readback_sva (
   input wire logic       clk,             // system clock
   input wire logic       rst_n,           // sync reset, active low
   input wire logic       cmdValid,        // transaction strobe
   input wire logic [7:0] cmdCode,         // command code
   input wire logic       cmdWrite,        // write flag
   input wire logic       clearFaults,     // clear pulse
   input wire logic       rdValid,         // answer strobe
   input wire logic       cmlFault,        // fault flag
   input wire logic       statusSummary,   // summary flag
   input wire logic       hostAlertOutput  // alert
);
   import telemetry_pkg::*;
   logic own;
   assign own = cmdCode inside {CMD_IN_CURRENT, CMD_OUT_CURRENT, CMD_TEMPERATURE,
                                CMD_OUT_POWER, CMD_IN_POWER, CMD_OUT_VOLTAGE};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_read_answered: assert property (cmdValid && !cmdWrite && own |=> rdValid)
      else $error("read of own command not answered");
   a_answer_has_cause: assert property (rdValid |-> $past(cmdValid && !cmdWrite && own))
      else $error("answer without a read");
   a_write_flags: assert property (cmdValid && cmdWrite && own |=> cmlFault && statusSummary)
      else $error("write did not set flags");
   a_alert_follows: assert property (hostAlertOutput == cmlFault)
      else $error("alert differs from fault flag");
   a_summary_pair: assert property (statusSummary == cmlFault)
      else $error("summary differs from fault flag");
   a_flag_sticky: assert property (cmlFault && !clearFaults |=> cmlFault)
      else $error("fault flag dropped");
   a_flag_cleared: assert property (clearFaults && !(cmdValid && cmdWrite && own) |=> !cmlFault)
      else $error("fault flag not cleared");
   a_flag_rise_cause: assert property ($rose(cmlFault) |-> $past(cmdValid && cmdWrite && own))
      else $error("fault flag without a write");
   a_unknown_silent: assert property (cmdValid && !own |=> !rdValid)
      else $error("unknown command answered");
endmodule // telemetry_readback_sva

bind telemetry_readback telemetry_readback_sva u_sva (.clk(clk), .rst_n(rst_n),
   .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrite(cmdWrite), .clearFaults(clearFaults),
   .rdValid(rdValid), .cmlFault(cmlFault), .statusSummary(statusSummary),
   .hostAlertOutput(hostAlertOutput));

/* File: telemetry_host.sv */
// host model: issues decoded read word and write transactions
// assumes the bench calls xfer; page and phase stay as levels between calls
`timescale 1ns/1ps
module telemetry_host (
   input  wire logic        clk,           // system clock
   input  wire logic        rdValid,       // answer strobe
   input  wire logic [15:0] rdData,        // answer word
   output logic             cmdValid,      // transaction strobe
   output logic [7:0]       cmdCode,       // command code
   output logic             cmdWrite,      // write flag
   output logic [15:0]      cmdWriteData,  // write payload
   output logic [7:0]       page,          // page level
   output logic [7:0]       phase          // phase level
);
   initial begin
      cmdValid = 1'b0;
      cmdCode = 8'h00;
      cmdWrite = 1'b0;
      cmdWriteData = 16'h0000;
      page = 8'h00;
      phase = 8'h00;
   end
   task automatic xfer(input logic [7:0] code, input logic wr, input logic [7:0] pg,
                       input logic [7:0] ph, output logic [15:0] word, output logic got);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdCode <= code;
      cmdWrite <= wr; // reads are whole read word transfers
      cmdWriteData <= 16'hA5C3;
      page <= pg; // channel select
      phase <= ph; // phase select
      @(posedge clk);
      cmdValid <= 1'b0;
      #1;
      got = rdValid;
      word = rdData;
   endtask
endmodule // telemetry_host

/* File: test_telemetry_readback.sv */
// self-checking bench for the telemetry readback bank
// bench drives measurements and clears; transactions go through telemetry_host
`timescale 1ns/1ps
module test_telemetry_readback;
   import telemetry_pkg::*;
   typedef struct packed {logic [7:0] code; logic [7:0] pg; logic [7:0] ph; logic [15:0] w;} row_t;
   localparam int unsigned SLOW = 200;
   logic clk, rst_n, cmdValid, cmdWrite, clearFaults, rdValid, got;
   logic cmlFault, statusSummary, hostAlertOutput;
   logic [7:0] cmdCode, page, phase, fs;
   logic [15:0] cmdWriteData, rdData, word;
   logic [1:0][4:0] tExp, pExp, vExp;
   logic [1:0][10:0] tMan, pMan, vMan;
   logic [7:0][4:0] iExp;
   logic [7:0][10:0] iMan;
   logic [4:0] pinExp, ofs;
   logic [10:0] pinMan, raw;
   int err_count = 0;
   int compares = 0;
   row_t rows [17] = '{'{8'h8D,8'h00,8'h00,16'h0811}, '{8'h8D,8'h01,8'h00,16'h1022},
      '{8'h8D,8'hFF,8'h00,16'h0811}, '{8'h96,8'h00,8'h00,16'h1C44}, '{8'h96,8'h01,8'h00,16'hE123},
      '{8'h96,8'hFF,8'h00,16'h1C44}, '{8'h97,8'h00,8'h00,16'hED55}, '{8'h97,8'h01,8'h00,16'hED55},
      '{8'hD4,8'h00,8'h00,16'hF200}, '{8'hD4,8'h01,8'h00,16'hF300}, '{8'h8C,8'h00,8'h00,16'hF810},
      '{8'h8C,8'h00,8'h05,16'hF815}, '{8'h8C,8'h00,8'h80,16'hF816}, '{8'h8C,8'h00,8'hFF,16'hF816},
      '{8'h8C,8'h01,8'h03,16'hF817}, '{8'h89,8'h01,8'h00,16'hF018},
      '{8'h8C,8'hFF,8'h07,16'hF816}};
   logic [7:0] codes [6] = '{8'h89, 8'h8C, 8'h8D, 8'h96, 8'h97, 8'hD4};

   telemetry_readback #(.SLOW_REFRESH_CYCLES(SLOW)) u_telemetry_readback (.clk(clk),
      .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
      .cmdWriteData(cmdWriteData), .page(page), .phase(phase), .clearFaults(clearFaults),
      .temperatureExponent(tExp), .temperatureMantissa(tMan), .outPowerExponent(pExp),
      .outPowerMantissa(pMan), .inPowerExponent(pinExp), .inPowerMantissa(pinMan),
      .outVoltageExponent(vExp), .outVoltageMantissa(vMan), .outCurrentExponent(iExp),
      .outCurrentMantissa(iMan), .inSenseRaw(raw), .inputCurrentFullScale(fs),
      .inputCurrentOffset(ofs), .rdValid(rdValid), .rdData(rdData), .cmlFault(cmlFault),
      .statusSummary(statusSummary), .hostAlertOutput(hostAlertOutput));
   telemetry_host u_telemetry_host (.clk(clk), .rdValid(rdValid), .rdData(rdData),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
      .cmdWriteData(cmdWriteData), .page(page), .phase(phase));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] pg, input logic [15:0] exp);
      u_telemetry_host.xfer(c, 1'b0, pg, 8'h00, word, got);
      check("read word", word, exp);
   endtask
   task automatic flags(input logic [2:0] exp);
      check("flags", {13'h0000, cmlFault, statusSummary, hostAlertOutput}, {13'h0000, exp});
   endtask
   task automatic clr();
      @(posedge clk);
      clearFaults <= 1'b1;
      @(posedge clk);
      clearFaults <= 1'b0;
      #1;
      flags(3'h0);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (10000) @(posedge clk);
      err_count++;
      test_done();
   end
   initial begin
      rst_n = 1'b0;
      clearFaults = 1'b0;
      tExp = {5'h02, 5'h01};
      tMan = {11'h022, 11'h011};
      pExp = {5'h1C, 5'h03};
      pMan = {11'h123, 11'h444};
      pinExp = 5'h1D;
      pinMan = 11'h555;
      vExp = {5'h1E, 5'h1E};
      vMan = {11'h300, 11'h200};
      for (int i = 0; i < 8; i++) begin
         iExp[i] = 5'h1F;
         iMan[i] = 11'h010 + 11'(i);
      end
      raw = 11'h028;
      fs = 8'h19;
      ofs = 5'h01;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check("reset word", rdData, WORD_RESET);
      check("reset answer", {15'h0000, rdValid}, 16'h0000);
      flags(3'h0);
      repeat (30) @(posedge clk);
      foreach (rows[i]) begin
         u_telemetry_host.xfer(rows[i].code, 1'b0, rows[i].pg, rows[i].ph, word, got);
         check("answer", {15'h0000, got}, 16'h0001);
         check("read word", word, rows[i].w);
      end
      @(posedge clk);
      tMan[1] <= 11'h055;
      iMan[7] <= 11'h077;
      rd(8'h8D, 8'h01, 16'h1022);
      repeat (SLOW + 40) @(posedge clk);
      rd(8'h8D, 8'h01, 16'h1055);
      rd(8'h8C, 8'h01, 16'hF817);
      repeat (FAST_CYCLES) @(posedge clk);
      rd(8'h8C, 8'h01, 16'hF877);
      foreach (codes[i]) begin
         u_telemetry_host.xfer(codes[i], 1'b1, 8'h01, 8'h00, word, got);
         check("write answer", {15'h0000, got}, 16'h0000);
         flags(3'h7);
         clr();
      end
      rd(8'h97, 8'h00, 16'hED55);
      fork
         u_telemetry_host.xfer(8'hD4, 1'b1, 8'h00, 8'h00, word, got);
         begin
            @(posedge clk);
            clearFaults <= 1'b1;
            @(posedge clk);
            clearFaults <= 1'b0;
         end
      join
      flags(3'h7);
      clr();
      u_telemetry_host.xfer(8'h20, 1'b1, 8'h00, 8'h00, word, got);
      u_telemetry_host.xfer(8'h20, 1'b0, 8'h00, 8'h00, word, got);
      check("unknown answer", {15'h0000, got}, 16'h0000);
      flags(3'h0);
      u_telemetry_host.xfer(8'h8D, 1'b1, 8'h00, 8'h00, word, got);
      flags(3'h7);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      flags(3'h0);
      repeat (30) @(posedge clk);
      rd(8'h8D, 8'h01, 16'h1055);
      test_done();
   end
endmodule // test_telemetry_readback
